// ===== pkg/bctr_map.svh
// constants of the bus cycle trace recorder
// assumes a 24-bit target address bus, 16-bit data and 3-bit cycle status
`ifndef BCTR_MAP_SVH
`define BCTR_MAP_SVH
`define BCTR_ADDR_W 24
`define BCTR_DATA_W 16
`define BCTR_STAT_W 3
`define BCTR_DELTA_W 16
`define BCTR_PTR_W 8
`define BCTR_DEPTH 256
`define BCTR_CNT_W 9
`define BCTR_NRANGE 2
`define BCTR_NTYPE 8
`define BCTR_PIPE_DEPTH 4
`define BCTR_PCNT_W 3
`define BCTR_REC_W 59
`define BCTR_REC_ADDR_LSB 0
`define BCTR_REC_DATA_LSB 24
`define BCTR_REC_STAT_LSB 40
`define BCTR_REC_DELTA_LSB 43
`define BCTR_TYPE_FETCH 3'h0
`define BCTR_DELTA_MAX 16'hffff
`define BCTR_PTR_ONE 8'h01
`define BCTR_CNT_ONE 9'h001
`define BCTR_PCNT_ONE 3'h1
`endif

// ===== pkg/bctr_pkg.sv
// types of the bus cycle trace recorder
// used by the recorder top and its pipeline decoder
package bctr_pkg;
  `include "bctr_map.svh"
  typedef enum logic [1:0] {
    BCTR_IDLE = 2'h0,
    BCTR_FREE = 2'h1,
    BCTR_STEP = 2'h3
  } bctr_state_e;
  typedef logic [`BCTR_PTR_W-1:0] bctr_ptr_t;
  typedef logic [`BCTR_REC_W-1:0] bctr_rec_t;
endpackage

// ===== verilog/bctr_pipe_decoder.sv
// pipeline decoder: tracks ring slots of stored opcode fetches not yet executed
// assumes exec pulses once per instruction taken from the queue, flush on discard
`timescale 1ns/1ns
`include "bctr_map.svh"
module bctr_pipe_decoder
  import bctr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic push,
  input wire logic [`BCTR_PTR_W-1:0] push_idx,
  input wire logic exec_pulse,
  input wire logic flush,
  output logic [`BCTR_PIPE_DEPTH-1:0] kill_vld,
  output logic [`BCTR_PIPE_DEPTH-1:0][`BCTR_PTR_W-1:0] kill_idx
);
  logic [`BCTR_PCNT_W-1:0] cnt_reg;
  logic [`BCTR_PCNT_W-1:0] cnt_next;
  logic [`BCTR_PIPE_DEPTH-1:0][`BCTR_PTR_W-1:0] idx_reg;
  logic [`BCTR_PIPE_DEPTH-1:0][`BCTR_PTR_W-1:0] idx_next;
  logic [`BCTR_PIPE_DEPTH-1:0] live;
  logic pop;

  assign pop = exec_pulse && (cnt_reg != '0);

  genvar g;
  generate
    for (g = 0; g < `BCTR_PIPE_DEPTH; g++) begin : g_live
      assign live[g] = (cnt_reg > `BCTR_PCNT_W'(g));
    end
  endgenerate

  // oldest slot leaves on execute; a full queue drops its oldest as executed
  always_comb begin
    logic [`BCTR_PCNT_W-1:0] c;
    c = cnt_reg;
    idx_next = idx_reg;
    if (pop) begin
      idx_next = idx_next >> `BCTR_PTR_W;
      c = c - `BCTR_PCNT_ONE;
    end
    if (push) begin
      if (c == `BCTR_PIPE_DEPTH) begin
        idx_next = idx_next >> `BCTR_PTR_W;
        c = c - `BCTR_PCNT_ONE;
      end
      idx_next[c[1:0]] = push_idx;
      c = c + `BCTR_PCNT_ONE;
    end
    cnt_next = c;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      idx_reg <= '0;
    end else if (clear) begin
      cnt_reg <= '0;
    end else if (flush) begin
      // fetches queued before a flush are never executed [R3]
      cnt_reg <= push ? `BCTR_PCNT_ONE : '0;
      idx_reg[0] <= push_idx;
    end else begin
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kill_vld <= '0;
      kill_idx <= '0;
    end else begin
      // an execute in the flush cycle spares only the oldest fetch [R3]
      kill_vld <= (flush && !clear) ? (pop ? (live >> 1) : live) : '0;
      kill_idx <= pop ? (idx_reg >> `BCTR_PTR_W) : idx_reg;
    end
  end

  property p_flush_empties;
    @(posedge ref_clk) disable iff (rst)
    (flush && !push && !clear) |=> (cnt_reg == '0);
  endproperty
  a_flush_empties: assert property (p_flush_empties) // [R3]
    else $error("pipeline queue not emptied by flush");
endmodule

// ===== verilog/bctr_recorder.sv
// bus cycle trace recorder top: control, filter, ring store, readout
// assumes one bus_valid pulse per external bus cycle, all inputs on ref_clk
// Operation
// R1: only cycles seen on the external bus are recorded, nothing internal.
// R2: a cycle is stored only while recording and its category is accepted.
// R3: stored opcode fetches that never execute are flagged by pipeline decoding.
// R4: recording starts when emulation starts; nothing is stored before that.
// R5: a single step records only during that step, then recording stops.
// R6: trigger, emulation halt or host stop command end recording, first wins.
// R7: every bus cycle seen while recording passes the filter check first.
// R8: wrong type or address outside all enabled ranges is discarded.
// R9: store is a ring; when full the newest record overwrites the oldest.
// R10: each recording start clears the buffer.
// R11: records keep bus order so the host reads them oldest first.
// R12: a record holds address, data, status, unexecuted flag and delta time.
`timescale 1ns/1ns
`include "bctr_map.svh"
module bctr_recorder
  import bctr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic emu_run,
  input wire logic step_start,
  input wire logic step_done,
  input wire logic trigger_hit,
  input wire logic host_stop,
  input wire logic bus_valid,
  input wire logic [`BCTR_ADDR_W-1:0] bus_addr,
  input wire logic [`BCTR_DATA_W-1:0] bus_data,
  input wire logic [`BCTR_STAT_W-1:0] bus_status,
  input wire logic pipe_exec,
  input wire logic pipe_flush,
  input wire logic [`BCTR_NTYPE-1:0] filt_type_en,
  input wire logic [`BCTR_NRANGE-1:0] filt_range_en,
  input wire logic [`BCTR_NRANGE-1:0][`BCTR_ADDR_W-1:0] filt_lo,
  input wire logic [`BCTR_NRANGE-1:0][`BCTR_ADDR_W-1:0] filt_hi,
  input wire logic rd_req,
  input wire logic [`BCTR_PTR_W-1:0] rd_index,
  output logic recording,
  output logic [`BCTR_CNT_W-1:0] rec_count,
  output logic rd_valid,
  output logic [`BCTR_ADDR_W-1:0] rd_addr,
  output logic [`BCTR_DATA_W-1:0] rd_data,
  output logic [`BCTR_STAT_W-1:0] rd_status,
  output logic rd_unexec,
  output logic [`BCTR_DELTA_W-1:0] rd_delta
);
  bctr_state_e state_reg;
  bctr_state_e state_next;
  logic run_d_reg;
  logic run_rise;
  logic run_fall;
  logic start;
  logic stop;
  logic type_ok;
  logic addr_ok;
  logic [`BCTR_NRANGE-1:0] in_range;
  logic store;
  bctr_ptr_t wr_ptr_reg;
  logic [`BCTR_CNT_W-1:0] count_reg;
  logic [`BCTR_DELTA_W-1:0] delta_reg;
  bctr_rec_t mem [`BCTR_DEPTH];
  logic [`BCTR_DEPTH-1:0] unexec_reg;
  logic [`BCTR_PIPE_DEPTH-1:0] kill_vld;
  logic [`BCTR_PIPE_DEPTH-1:0][`BCTR_PTR_W-1:0] kill_idx;
  bctr_ptr_t oldest;
  bctr_ptr_t rd_slot;
  bctr_rec_t rd_rec;

  assign run_rise = emu_run && !run_d_reg;
  assign run_fall = !emu_run && run_d_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= emu_run;
    end
  end

  // start only from idle; a step request while running is ignored
  assign start = (state_reg == BCTR_IDLE) && (run_rise || step_start); // [R4] [R5]
  assign stop = trigger_hit || run_fall || host_stop; // [R6]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BCTR_IDLE: begin
        if (run_rise) begin
          state_next = BCTR_FREE; // [R4]
        end else if (step_start) begin
          state_next = BCTR_STEP; // [R5]
        end
      end
      BCTR_FREE: begin
        if (stop) begin
          state_next = BCTR_IDLE; // [R6]
        end
      end
      BCTR_STEP: begin
        if (stop || step_done) begin
          state_next = BCTR_IDLE; // [R5] [R6]
        end
      end
      default: begin
        state_next = BCTR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= BCTR_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign recording = (state_reg != BCTR_IDLE);

  // no enabled range means the address filter is open
  genvar g;
  generate
    for (g = 0; g < `BCTR_NRANGE; g++) begin : g_range
      assign in_range[g] = filt_range_en[g] && (bus_addr >= filt_lo[g])
                           && (bus_addr <= filt_hi[g]);
    end
  endgenerate

  assign type_ok = filt_type_en[bus_status]; // [R8]
  assign addr_ok = (filt_range_en == '0) || (|in_range); // [R8]
  // only real bus cycles seen while recording reach the filter [R1] [R7]
  assign store = recording && bus_valid && type_ok && addr_ok; // [R2]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      count_reg <= '0;
    end else if (start) begin
      wr_ptr_reg <= '0; // [R10]
      count_reg <= '0; // [R10]
    end else if (store) begin
      // pointer wraps and overwrites the oldest slot [R9] [R11]
      wr_ptr_reg <= wr_ptr_reg + `BCTR_PTR_ONE;
      if (count_reg != `BCTR_DEPTH) begin
        count_reg <= count_reg + `BCTR_CNT_ONE;
      end
    end
  end

  // saturates so a long quiet gap still reads as the longest time
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      delta_reg <= '0;
    end else if (start || store) begin
      delta_reg <= '0; // [R12]
    end else if (delta_reg != `BCTR_DELTA_MAX) begin
      delta_reg <= delta_reg + 1'b1;
    end
  end

  // record memory: no reset, contents beyond the count are never shown
  always_ff @(posedge ref_clk) begin
    if (store) begin
      mem[wr_ptr_reg] <= {delta_reg, bus_status, bus_data, bus_addr}; // [R12]
    end
  end

  bctr_pipe_decoder u_decoder (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(start),
    .push(store && (bus_status == `BCTR_TYPE_FETCH)),
    .push_idx(wr_ptr_reg),
    .exec_pulse(pipe_exec),
    .flush(pipe_flush),
    .kill_vld(kill_vld),
    .kill_idx(kill_idx)
  );

  // a fresh store clears its slot flag; later kills mark it unexecuted
  generate
    for (g = 0; g < `BCTR_DEPTH; g++) begin : g_flag
      logic hit;
      always_comb begin
        hit = 1'b0;
        for (int k = 0; k < `BCTR_PIPE_DEPTH; k++) begin
          if (kill_vld[k] && (kill_idx[k] == `BCTR_PTR_W'(g))) begin
            hit = 1'b1;
          end
        end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          unexec_reg[g] <= 1'b0;
        end else if (store && (wr_ptr_reg == `BCTR_PTR_W'(g))) begin
          unexec_reg[g] <= 1'b0;
        end else if (hit) begin
          unexec_reg[g] <= 1'b1; // [R3]
        end
      end
    end
  endgenerate

  // index 0 is always the oldest record still held [R11]
  assign oldest = (count_reg == `BCTR_DEPTH) ? wr_ptr_reg : '0;
  assign rd_slot = oldest + rd_index;
  assign rd_rec = mem[rd_slot];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_addr <= '0;
      rd_data <= '0;
      rd_status <= '0;
      rd_unexec <= 1'b0;
      rd_delta <= '0;
    end else begin
      rd_valid <= rd_req;
      if (rd_req && ({1'b0, rd_index} < count_reg)) begin
        rd_addr <= rd_rec[`BCTR_REC_ADDR_LSB +: `BCTR_ADDR_W];
        rd_data <= rd_rec[`BCTR_REC_DATA_LSB +: `BCTR_DATA_W];
        rd_status <= rd_rec[`BCTR_REC_STAT_LSB +: `BCTR_STAT_W];
        rd_delta <= rd_rec[`BCTR_REC_DELTA_LSB +: `BCTR_DELTA_W];
        rd_unexec <= unexec_reg[rd_slot]; // [R3]
      end else if (rd_req) begin
        rd_addr <= '0;
        rd_data <= '0;
        rd_status <= '0;
        rd_delta <= '0;
        rd_unexec <= 1'b0;
      end
    end
  end

  assign rec_count = count_reg;

  property p_store_needs_rec;
    @(posedge ref_clk) disable iff (rst)
    store |-> recording && type_ok;
  endproperty
  a_store_needs_rec: assert property (p_store_needs_rec) // [R2]
    else $error("cycle stored while not recording or type rejected");

  property p_no_bus_no_store;
    @(posedge ref_clk) disable iff (rst)
    !bus_valid |=> $stable(wr_ptr_reg) || $past(start);
  endproperty
  a_no_bus_no_store: assert property (p_no_bus_no_store) // [R1]
    else $error("write pointer moved without a bus cycle");

  property p_run_starts;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == BCTR_IDLE) && run_rise |=> (state_reg == BCTR_FREE) && (count_reg == '0);
  endproperty
  a_run_starts: assert property (p_run_starts) // [R4]
    else $error("emulation start did not begin recording");

  property p_step_ends;
    @(posedge ref_clk) disable iff (rst)
    (state_reg == BCTR_STEP) && step_done |=> !recording;
  endproperty
  a_step_ends: assert property (p_step_ends) // [R5]
    else $error("recording still on after step done");

  property p_stop_events;
    @(posedge ref_clk) disable iff (rst)
    recording && (trigger_hit || host_stop || run_fall) |=>
      !recording ##1 (!recording || $past(start));
  endproperty
  a_stop_events: assert property (p_stop_events) // [R6]
    else $error("recording not stopped by stop event");

  property p_filter_addr;
    @(posedge ref_clk) disable iff (rst)
    store && (filt_range_en != '0) |->
      (filt_range_en[0] && (bus_addr >= filt_lo[0]) && (bus_addr <= filt_hi[0]))
      || (filt_range_en[1] && (bus_addr >= filt_lo[1]) && (bus_addr <= filt_hi[1]));
  endproperty
  a_filter_addr: assert property (p_filter_addr) // [R8]
    else $error("cycle outside every enabled range stored");

  property p_ring_wrap;
    @(posedge ref_clk) disable iff (rst)
    store && !start |=> wr_ptr_reg == $past(wr_ptr_reg) + `BCTR_PTR_ONE;
  endproperty
  a_ring_wrap: assert property (p_ring_wrap) // [R9]
    else $error("write pointer did not advance by one");

  property p_start_clears;
    @(posedge ref_clk) disable iff (rst)
    start |=> (count_reg == '0) && (wr_ptr_reg == '0) && recording;
  endproperty
  a_start_clears: assert property (p_start_clears) // [R10]
    else $error("buffer not cleared at recording start");
endmodule

// ===== bench/bctr_cpu_model.sv
// target cpu bus model: random external cycles or one directed cycle
// assumes bench clock; fields are scrambled while no cycle is on the bus
`timescale 1ns/1ns
`include "bctr_map.svh"
module bctr_cpu_model
  import bctr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic en,
  input wire logic req,
  input wire logic [`BCTR_ADDR_W-1:0] req_addr,
  input wire logic [`BCTR_STAT_W-1:0] req_stat,
  output logic bus_valid,
  output logic [`BCTR_ADDR_W-1:0] bus_addr,
  output logic [`BCTR_DATA_W-1:0] bus_data,
  output logic [`BCTR_STAT_W-1:0] bus_status
);
  int seed = 35;
  logic r;
  logic e;
  initial begin
    bus_valid = 1'h0;
    {bus_addr, bus_data, bus_status} = '0;
  end
  // only real external cycles raise bus_valid
  always @(posedge ref_clk) begin
    r = req;
    e = en;
    #1;
    if (r) begin
      bus_valid = 1'h1;
      bus_addr = req_addr;
      bus_data = 16'($random(seed));
      bus_status = req_stat;
    end else if (e && ($random(seed) % 4) != 0) begin
      bus_valid = 1'h1;
      // small window so that address ranges really hit
      bus_addr = {16'h0000, 8'($random(seed))};
      bus_data = 16'($random(seed));
      bus_status = 3'($random(seed));
    end else begin
      // released bus must not look like the last cycle
      bus_valid = 1'h0;
      {bus_addr, bus_data, bus_status} = ~{bus_addr, bus_data, bus_status};
    end
  end
endmodule

// ===== bench/bctr_recorder_bench.sv
// self-checking bench of the bus cycle trace recorder
// assumes the cpu model on the bus side, host control driven here
`timescale 1ns/1ns
`include "bctr_map.svh"
module bctr_recorder_bench;
  import bctr_pkg::*;
  logic ref_clk, rst, emu_run, step_start, step_done, trigger_hit, host_stop;
  logic pipe_exec, pipe_flush, rd_req, en, req, bus_valid, recording;
  logic rd_valid, rd_unexec, rec_prev;
  logic [`BCTR_ADDR_W-1:0] bus_addr, req_addr, rd_addr;
  logic [`BCTR_DATA_W-1:0] bus_data, rd_data;
  logic [`BCTR_STAT_W-1:0] bus_status, req_stat, rd_status;
  logic [`BCTR_NTYPE-1:0] filt_type_en;
  logic [`BCTR_NRANGE-1:0] filt_range_en;
  logic [`BCTR_NRANGE-1:0][`BCTR_ADDR_W-1:0] filt_lo, filt_hi;
  logic [`BCTR_PTR_W-1:0] rd_index;
  logic [`BCTR_CNT_W-1:0] rec_count;
  logic [`BCTR_DELTA_W-1:0] rd_delta;
  logic [`BCTR_REC_W-1:0] exp_q[$];
  logic [`BCTR_DELTA_W-1:0] exp_delta;
  int bad_count, checked, cyc, seed = 35;

  bctr_recorder DUT (.ref_clk, .rst, .emu_run, .step_start, .step_done,
    .trigger_hit, .host_stop, .bus_valid, .bus_addr, .bus_data, .bus_status,
    .pipe_exec, .pipe_flush, .filt_type_en, .filt_range_en, .filt_lo,
    .filt_hi, .rd_req, .rd_index, .recording, .rec_count, .rd_valid,
    .rd_addr, .rd_data, .rd_status, .rd_unexec, .rd_delta);
  bctr_cpu_model cpu (.ref_clk, .en, .req, .req_addr, .req_stat, .bus_valid,
    .bus_addr, .bus_data, .bus_status);

  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end

  function automatic logic pass(logic [23:0] a, logic [2:0] s);
    pass = filt_type_en[s] && (filt_range_en == 2'h0 ||
      (filt_range_en[0] && a >= filt_lo[0] && a <= filt_hi[0]) ||
      (filt_range_en[1] && a >= filt_lo[1] && a <= filt_hi[1]));
  endfunction

  // reference ring, fed from what the bus really showed
  always @(posedge ref_clk) begin
    if (recording && !rec_prev) begin
      exp_q.delete();
      exp_delta = '0;
    end
    if (recording && bus_valid && pass(bus_addr, bus_status)) begin
      if (exp_q.size() == `BCTR_DEPTH) void'(exp_q.pop_front());
      exp_q.push_back({exp_delta, bus_addr, bus_data, bus_status});
      exp_delta = '0;
    end else if (exp_delta != `BCTR_DELTA_MAX) begin
      // time since the last stored record, held at its ceiling
      exp_delta = exp_delta + 16'h0001;
    end
    rec_prev <= recording;
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      results();
    end
  end

  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(string name, logic [63:0] seen, logic [63:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, want, seen);
    end
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
  endtask

  task automatic rd(int i);
    rd_index = 8'(i);
    pulse(rd_req);
    check("rd_valid", 64'(rd_valid), 64'h1);
    // one idle edge so back to back reads never touch rd_req twice at once
    tick();
  endtask

  task automatic read_all();
    check("rec_count", 64'(rec_count), 64'(exp_q.size()));
    for (int i = 0; i < exp_q.size(); i++) begin
      rd(i);
      check("record", {rd_delta, rd_addr, rd_data, rd_status}, 64'(exp_q[i]));
    end
  endtask

  task automatic start();
    emu_run = 1'h1;
    tick();
    check("recording", 64'(recording), 64'h1);
    check("rec_count", 64'(rec_count), 64'h0);
  endtask

  initial begin
    {emu_run, step_start, step_done, trigger_hit, host_stop} = '0;
    {pipe_exec, pipe_flush, rd_req, en, req, rec_prev} = '0;
    {req_addr, req_stat, rd_index, filt_lo, filt_hi} = '0;
    filt_type_en = 8'hff;
    filt_range_en = 2'h0;
    rst = 1'h1;
    tick(12);
    rst = 1'h0;
    tick();
    check("rec_count", 64'(rec_count), 64'h0);
    en = 1'h1;
    tick(20);
    check("rec_count", 64'(rec_count), 64'h0);
    $display("test idle done");
    for (int k = 0; k < 6; k++) begin
      filt_type_en = 8'($random(seed));
      filt_range_en = k < 3 ? 2'($random(seed)) : 2'h0;
      for (int j = 0; j < 2; j++) begin
        filt_lo[j] = 24'($random(seed) & 8'hff);
        filt_hi[j] = filt_lo[j] + 24'($random(seed) & 8'h7f);
      end
      start();
      tick(40);
      // the three ways to end a recording
      if (k % 3 == 0) pulse(trigger_hit);
      else if (k % 3 == 1) emu_run = 1'h0;
      else pulse(host_stop);
      if (k % 3 == 1) tick();
      check("recording", 64'(recording), 64'h0);
      tick(5);
      read_all();
      emu_run = 1'h0;
      tick();
      $display("test filter and stop done");
    end
    {filt_type_en, filt_range_en} = {8'hff, 2'h0};
    start();
    tick(400);
    pulse(host_stop);
    read_all();
    emu_run = 1'h0;
    $display("test ring wrap done");
    pulse(step_start);
    check("recording", 64'(recording), 64'h1);
    tick(8);
    pulse(step_start);
    pulse(step_done);
    check("recording", 64'(recording), 64'h0);
    tick(5);
    read_all();
    $display("test single step done");
    en = 1'h0;
    start();
    req_addr = 24'h000010;
    pulse(req);
    tick(2);
    pulse(pipe_exec);
    req_addr = 24'h000012;
    pulse(req);
    tick(2);
    pulse(pipe_flush);
    tick(2);
    pulse(host_stop);
    emu_run = 1'h0;
    check("rec_count", 64'(rec_count), 64'h2);
    rd(0);
    check("rd_unexec", 64'(rd_unexec), 64'h0);
    rd(1);
    check("rd_unexec", 64'(rd_unexec), 64'h1);
    rd(2);
    check("rd_addr", 64'(rd_addr), 64'h0);
    $display("test pipeline done");
    results();
  end
endmodule
